// ===== rtl/spio_pkg.sv
// Purpose: Shared constants and carrier types for the shared-pin I/O port block.
// Assumes: Registers are 32-bit words on a classic Wishbone slave, byte addressed.
// Notes:   Narrow registers sit in the low bits; upper bits read as zero.
`default_nettype none
package spio_pkg;
  localparam int PORT_W   = 16;
  localparam int CN_W     = 22;
  localparam int CN_LO_W  = 16;
  localparam int CN_HI_W  = CN_W - CN_LO_W;
  localparam int ADR_W    = 8;

  // Register byte offsets.
  localparam logic [ADR_W-1:0] OFS_DIRECTION   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_LATCH       = 8'h04;
  localparam logic [ADR_W-1:0] OFS_PIN_LEVEL   = 8'h08;
  localparam logic [ADR_W-1:0] OFS_OPEN_DRAIN  = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CN_EN_LOW   = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CN_EN_HIGH  = 8'h14;
  localparam logic [ADR_W-1:0] OFS_PULLUP_LOW  = 8'h18;
  localparam logic [ADR_W-1:0] OFS_PULLUP_HIGH = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_ANALOG_CFG  = 8'h20;
  localparam logic [ADR_W-1:0] OFS_STATUS      = 8'h24;
  localparam logic [ADR_W-1:0] OFS_CN_LEVEL    = 8'h28;

  // Status register fields.
  localparam int STAT_CHANGE_BIT = 0;
  localparam int STAT_PRIMED_BIT = 1;

  // Values after reset.
  localparam logic [PORT_W-1:0] RST_DIRECTION = 16'hFFFF;
  localparam logic [PORT_W-1:0] RST_LATCH     = 16'h0000;
  localparam logic [PORT_W-1:0] RST_OPEN_DRN  = 16'h0000;
  localparam logic [PORT_W-1:0] RST_ANALOG    = 16'h0000;
  localparam logic [CN_W-1:0]   RST_CN_EN     = 22'h000000;
  localparam logic [CN_W-1:0]   RST_PULLUP    = 22'h000000;

  // Cycles between a pin change and its effect on readback.
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [3:0]        sel;
    logic [ADR_W-1:0]  adr;
    logic [31:0]       dat;
  } spio_wb_req_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       dat;
  } spio_wb_rsp_t;
endpackage : spio_pkg
`default_nettype wire

// ===== rtl/spio_sync2.sv
// Purpose: Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes: Each bit is independent; no multi-bit coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module spio_sync2
  import spio_pkg::*;
#(
  parameter int WIDTH = PORT_W
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= '0;
      syncOut    <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end
endmodule : spio_sync2
`default_nettype wire

// ===== rtl/spio_change_detect.sv
// Purpose: Change-of-state detector with one shared sticky flag.
// Assumes: levelIn is already synchronised to clock.
// Notes:   The first cycle after reset only captures levels, so a pulled-up
//          pin does not raise a false change on its way out of reset.
`timescale 1ns/1ps
`default_nettype none
module spio_change_detect
  import spio_pkg::*;
#(
  parameter int WIDTH = CN_W
)
(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Inputs
  input  wire logic [WIDTH-1:0] levelIn,
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic             clearFlag,
  // Outputs
  output logic                  changeFlag,
  output logic                  primed
);
  logic [WIDTH-1:0] prev_reg;
  logic             changeSeen;

  assign changeSeen = primed && (|(enable & (levelIn ^ prev_reg)));

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      prev_reg <= '0;
      primed   <= 1'b0;
    end
    else
    begin
      prev_reg <= levelIn;
      primed   <= 1'b1;
    end
  end

  // A change in the clearing cycle keeps the flag set.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      changeFlag <= 1'b0;
    else if (changeSeen)
      changeFlag <= 1'b1;
    else if (clearFlag)
      changeFlag <= 1'b0;
  end
endmodule : spio_change_detect
`default_nettype wire

// ===== rtl/spio_port.sv
// Purpose: Shared-pin parallel I/O port with input change notification.
// Assumes: Classic Wishbone slave, 32-bit data, one clock at 200 MHz. The clock
//          of this block stays on in Sleep; only the processor clocks stop.
// Notes:   Pin levels pass two flip-flops before any read or detection.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module spio_port
  import spio_pkg::*;
#(
  parameter int                NUM_PINS  = PORT_W,
  parameter int                NUM_CN    = CN_W,
  parameter logic [PORT_W-1:0] IMPL_MASK = 16'hFFFF
)
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                resetn,
  // Wishbone slave
  input  wire spio_wb_req_t        wbReq,
  output spio_wb_rsp_t             wbRsp,
  // Port pins
  input  wire logic [PORT_W-1:0]   padIn,
  output logic      [PORT_W-1:0]   padOut,
  output logic      [PORT_W-1:0]   padOe,
  // Sharing peripheral
  input  wire logic [PORT_W-1:0]   periphEnable,
  input  wire logic [PORT_W-1:0]   periphDriving,
  input  wire logic [PORT_W-1:0]   periphOut,
  output logic      [PORT_W-1:0]   periphIn,
  // Change notification
  input  wire logic [CN_W-1:0]     changeNoticeIn,
  output logic      [CN_W-1:0]     weakPullupOn,
  // Power management
  input  wire logic                powerSave,
  output logic                     changeIrq,
  output logic                     wakeRequest
);
  // Pins beyond the configured count behave as unimplemented, and change inputs beyond theirs are left out of detection,
  // so a smaller derivative needs no change to the register map.
  localparam logic [PORT_W-1:0] PIN_LIMIT = {PORT_W{1'b1}} >> (PORT_W - NUM_PINS);
  localparam logic [PORT_W-1:0] PIN_MASK  = IMPL_MASK & PIN_LIMIT;
  localparam logic [CN_W-1:0]   CN_MASK   = {CN_W{1'b1}} >> (CN_W - NUM_CN);

  // Register state.
  logic [PORT_W-1:0] direction_reg;
  logic [PORT_W-1:0] latch_reg;
  logic [PORT_W-1:0] openDrain_reg;
  logic [PORT_W-1:0] analog_reg;
  logic [CN_W-1:0]   cnEnable_reg;
  logic [CN_W-1:0]   pullup_reg;

  // Bus handshake.
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              access;
  logic              wrAccess;
  logic [31:0]       wMask;
  // Write data and byte enables cut to the width of each register.
  logic [PORT_W-1:0] wMaskPort;
  logic [PORT_W-1:0] wDataPort;
  logic [CN_HI_W-1:0] wMaskHigh;
  logic [CN_HI_W-1:0] wDataHigh;

  // Write strobes, one per writable register; hitLatch serves both the latch and the pin level address.
  logic              hitDirection;
  logic              hitLatch;
  logic              hitOpenDrain;
  logic              hitAnalog;
  logic              hitEnableLow;
  logic              hitEnableHigh;
  logic              hitPullupLow;
  logic              hitPullupHigh;
  logic              hitStatus;

  // Pin side.
  logic [PORT_W-1:0] padSync;
  logic [CN_W-1:0]   cnSync;
  logic [PORT_W-1:0] periphOwns;
  logic [PORT_W-1:0] portOwns;
  logic [PORT_W-1:0] driveVal;
  logic [PORT_W-1:0] driveEn;
  logic [PORT_W-1:0] pinRead;

  // Change notification.
  logic              changeFlag;
  logic              cnPrimed;
  logic              clearChange;

  // Merge write data into a port-wide register under the byte enables.
  function automatic logic [PORT_W-1:0] merge(
    input logic [PORT_W-1:0] oldVal,
    input logic [PORT_W-1:0] newVal,
    input logic [PORT_W-1:0] mask
  );
    merge = (oldVal & ~mask) | (newVal & mask);
  endfunction : merge

  spio_sync2 #(
    .WIDTH   (PORT_W)
  ) uPadSync (
    .clock   (clock),
    .resetn  (resetn),
    .asyncIn (padIn),
    .syncOut (padSync)
  );

  spio_sync2 #(
    .WIDTH   (CN_W)
  ) uCnSync (
    .clock   (clock),
    .resetn  (resetn),
    .asyncIn (changeNoticeIn),
    .syncOut (cnSync)
  );

  // Bus slave: one access per request, ack one cycle after strobe.
  assign access   = wbReq.cyc && wbReq.stb && !ack_reg;
  assign wrAccess = access && wbReq.we;
  assign wMask    = {{8{wbReq.sel[3]}}, {8{wbReq.sel[2]}},
                     {8{wbReq.sel[1]}}, {8{wbReq.sel[0]}}};

  assign wMaskPort = wMask[PORT_W-1:0];
  assign wDataPort = wbReq.dat[PORT_W-1:0];
  assign wMaskHigh = wMask[CN_HI_W-1:0];
  assign wDataHigh = wbReq.dat[CN_HI_W-1:0];

  // The pin level address writes the latch, as a port write does.
  assign hitDirection  = wrAccess && wbReq.adr == OFS_DIRECTION;
  assign hitLatch      = wrAccess && (wbReq.adr == OFS_LATCH || wbReq.adr == OFS_PIN_LEVEL);
  assign hitOpenDrain  = wrAccess && wbReq.adr == OFS_OPEN_DRAIN;
  assign hitAnalog     = wrAccess && wbReq.adr == OFS_ANALOG_CFG;
  assign hitEnableLow  = wrAccess && wbReq.adr == OFS_CN_EN_LOW;
  assign hitEnableHigh = wrAccess && wbReq.adr == OFS_CN_EN_HIGH;
  assign hitPullupLow  = wrAccess && wbReq.adr == OFS_PULLUP_LOW;
  assign hitPullupHigh = wrAccess && wbReq.adr == OFS_PULLUP_HIGH;
  assign hitStatus     = wrAccess && wbReq.adr == OFS_STATUS;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ack_reg <= 1'b0;
    else
      ack_reg <= access;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 32'h00000000;
    else if (access && !wbReq.we)
      rdata_reg <= rdata_next;
  end

  assign wbRsp = '{ack: ack_reg, dat: rdata_reg};

  // Direction: unimplemented bits are held at zero.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      direction_reg <= RST_DIRECTION & PIN_MASK;
    else if (hitDirection)
      direction_reg <= merge(direction_reg, wDataPort, wMaskPort) & PIN_MASK;
  end

  // Latch: written from either the latch or the pin level address.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      latch_reg <= RST_LATCH;
    else if (hitLatch)
      latch_reg <= merge(latch_reg, wDataPort, wMaskPort) & PIN_MASK;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      openDrain_reg <= RST_OPEN_DRN;
    else if (hitOpenDrain)
      openDrain_reg <= merge(openDrain_reg, wDataPort, wMaskPort) & PIN_MASK;
  end

  // Analog select: a set bit marks the pin as an analog input channel.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      analog_reg <= RST_ANALOG;
    else if (hitAnalog)
      analog_reg <= merge(analog_reg, wDataPort, wMaskPort) & PIN_MASK;
  end

  // Change enables are split over a low and a high register; the high register
  // only holds the few inputs above the first sixteen.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      cnEnable_reg <= RST_CN_EN;
    else if (hitEnableLow)
      cnEnable_reg[CN_LO_W-1:0] <= merge(cnEnable_reg[CN_LO_W-1:0], wDataPort, wMaskPort);
    else if (hitEnableHigh)
      cnEnable_reg[CN_W-1:CN_LO_W] <= (cnEnable_reg[CN_W-1:CN_LO_W] & ~wMaskHigh)
                                      | (wDataHigh & wMaskHigh);
  end

  // Pull-up enables use the same low and high split as the change enables.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pullup_reg <= RST_PULLUP;
    else if (hitPullupLow)
      pullup_reg[CN_LO_W-1:0] <= merge(pullup_reg[CN_LO_W-1:0], wDataPort, wMaskPort);
    else if (hitPullupHigh)
      pullup_reg[CN_W-1:CN_LO_W] <= (pullup_reg[CN_W-1:CN_LO_W] & ~wMaskHigh)
                                    | (wDataHigh & wMaskHigh);
  end

  assign weakPullupOn = pullup_reg;

  // Pin ownership. A peripheral only takes the pin while it actually drives.
  assign periphOwns = periphEnable & periphDriving & PIN_MASK;
  assign portOwns   = ~periphOwns & ~direction_reg & PIN_MASK;

  always_comb
  begin
    for (int i = 0; i < PORT_W; i++)
    begin
      if (periphOwns[i])
      begin
        driveVal[i] = periphOut[i];
        driveEn[i]  = 1'b1;
      end
      else
      begin
        driveVal[i] = latch_reg[i];
        driveEn[i]  = portOwns[i];
      end
    end
  end

  // Open drain drives only lows; a high releases the pin for an external pull-up.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      padOut <= 16'h0000;
      padOe  <= 16'h0000;
    end
    else
    begin
      padOut <= driveVal & ~openDrain_reg;
      padOe  <= driveEn & ~(openDrain_reg & driveVal);
    end
  end

  // The peripheral sees the pin only while the port is not driving it.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      periphIn <= 16'h0000;
    else
      periphIn <= padSync & ~portOwns;
  end

  // Readback lags the pin by the two synchroniser stages, so software must leave
  // a short gap between writing a port and reading the same port back.
  assign pinRead = padSync & ~analog_reg & PIN_MASK;

  // Change detection runs on this clock, which keeps going in Sleep.
  assign clearChange = hitStatus && wbReq.sel[0] && wbReq.dat[STAT_CHANGE_BIT];

  spio_change_detect #(
    .WIDTH      (CN_W)
  ) uChange (
    .clock      (clock),
    .resetn     (resetn),
    .levelIn    (cnSync),
    .enable     (cnEnable_reg & CN_MASK),
    .clearFlag  (clearChange),
    .changeFlag (changeFlag),
    .primed     (cnPrimed)
  );

  assign changeIrq   = changeFlag;
  assign wakeRequest = powerSave && changeFlag;

  // Read multiplexer; unmapped addresses read zero and still acknowledge.
  always_comb
  begin
    rdata_next = 32'h00000000;
    case (wbReq.adr)
      OFS_DIRECTION:
        rdata_next[PORT_W-1:0] = direction_reg & IMPL_MASK;
      OFS_LATCH:
        rdata_next[PORT_W-1:0] = latch_reg & IMPL_MASK;
      OFS_PIN_LEVEL:
        rdata_next[PORT_W-1:0] = pinRead;
      OFS_OPEN_DRAIN:
        rdata_next[PORT_W-1:0] = openDrain_reg;
      OFS_CN_EN_LOW:
        rdata_next[CN_LO_W-1:0] = cnEnable_reg[CN_LO_W-1:0];
      OFS_CN_EN_HIGH:
        rdata_next[CN_HI_W-1:0] = cnEnable_reg[CN_W-1:CN_LO_W];
      OFS_PULLUP_LOW:
        rdata_next[CN_LO_W-1:0] = pullup_reg[CN_LO_W-1:0];
      OFS_PULLUP_HIGH:
        rdata_next[CN_HI_W-1:0] = pullup_reg[CN_W-1:CN_LO_W];
      OFS_ANALOG_CFG:
        rdata_next[PORT_W-1:0] = analog_reg;
      OFS_STATUS:
      begin
        rdata_next[STAT_CHANGE_BIT] = changeFlag;
        rdata_next[STAT_PRIMED_BIT] = cnPrimed;
      end
      OFS_CN_LEVEL:
        rdata_next[CN_W-1:0] = cnSync;
      default:
        rdata_next = 32'h00000000;
    endcase
  end
endmodule : spio_port
`default_nettype wire

// ===== tb/spio_port_props.sv
// Purpose: Concurrent checks on the ports of the shared-pin port top.
// Assumes: One clock; resetn is asynchronous and active low.
// Notes:   Bound into every spio_port instance.
`timescale 1ns/1ps
`default_nettype none
module spio_port_props
  import spio_pkg::*;
#(
  parameter logic [PORT_W-1:0] IMPL_MASK = 16'hFFFF
)
(
  // Clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // Observed ports
  input wire spio_wb_req_t      wbReq,
  input wire spio_wb_rsp_t      wbRsp,
  input wire logic [PORT_W-1:0] padOe,
  input wire logic [CN_W-1:0]   changeNoticeIn,
  input wire logic [CN_W-1:0]   weakPullupOn,
  input wire logic              powerSave,
  input wire logic              changeIrq,
  input wire logic              wakeRequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic take;
  logic clr;
  assign take = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign clr  = take && wbReq.we && wbReq.sel[0] && wbReq.adr == OFS_STATUS && wbReq.dat[0];

  ack_answer_a: assert property (take |=> wbRsp.ack) else $error("request not acknowledged");
  ack_single_a: assert property (wbRsp.ack |=> !wbRsp.ack) else $error("ack held too long");
  wake_gate_a:
    assert property (wakeRequest == (powerSave && changeIrq)) else $error("wake request wrong");
  reset_inputs_a:
    assert property ($rose(resetn) |-> padOe == '0 && !changeIrq) else $error("not quiet after reset");
  unimpl_quiet_a:
    assert property ((padOe & ~IMPL_MASK) == '0) else $error("unimplemented pin driven");
  pullup_write_a:
    assert property ($changed(weakPullupOn) |-> wbRsp.ack && wbReq.we) else $error("pull-up moved alone");
  irq_sticky_a:
    assert property ($fell(changeIrq) |-> $past(clr)) else $error("change flag dropped");
  irq_cause_a:
    assert property ($rose(changeIrq) |-> $past(changeNoticeIn, 3) != $past(changeNoticeIn, 4))
      else $error("change flag without input change");
  unmapped_zero_a:
    assert property (wbRsp.ack && !wbReq.we && wbReq.adr > OFS_CN_LEVEL |-> wbRsp.dat == '0)
      else $error("unmapped read not zero");

  cover property ($rose(changeIrq));
  cover property (wakeRequest);
  cover property (clr && changeIrq);
endmodule : spio_port_props

bind spio_port spio_port_props #(.IMPL_MASK(IMPL_MASK)) u_props (.clock(clock), .resetn(resetn),
  .wbReq(wbReq), .wbRsp(wbRsp), .padOe(padOe), .changeNoticeIn(changeNoticeIn),
  .weakPullupOn(weakPullupOn), .powerSave(powerSave), .changeIrq(changeIrq), .wakeRequest(wakeRequest));
`default_nettype wire

// ===== tb/spio_pins_model.sv
// Purpose: Board circuitry on the port pins and change inputs.
// Assumes: Every port pin carries an external pull-up resistor.
// Notes:   A floating change input follows its weak pull-up, else a pull-down.
`timescale 1ns/1ps
`default_nettype none
module spio_pins_model
  import spio_pkg::*;
(
  // Port pins
  input  wire logic [PORT_W-1:0] padOut,
  input  wire logic [PORT_W-1:0] padOe,
  input  wire logic [PORT_W-1:0] extOe,
  input  wire logic [PORT_W-1:0] extVal,
  output logic      [PORT_W-1:0] padIn,
  // Change inputs
  input  wire logic              cnDrive,
  input  wire logic [CN_W-1:0]   cnVal,
  input  wire logic [CN_W-1:0]   weakPullupOn,
  output logic      [CN_W-1:0]   changeNoticeIn
);
  // Released pins float high, which is what makes an open-drain high readable.
  assign padIn = (padOe & padOut) | (~padOe & extOe & extVal) | (~padOe & ~extOe);
  assign changeNoticeIn = cnDrive ? cnVal : weakPullupOn;
endmodule : spio_pins_model
`default_nettype wire

// ===== tb/test_shared_pin_io_port_change_notify.sv
// Purpose: Self-checking bench for the shared-pin port with change notice.
// Assumes: The bench only drives right after a rising edge.
// Notes:   Pin 15 is left unimplemented so its zero readback is exercised.
`timescale 1ns/1ps
`default_nettype none
module test_shared_pin_io_port_change_notify
  import spio_pkg::*;
;
  localparam logic [15:0] MASK = 16'h7FFF;
  logic         clock, resetn, powerSave, changeIrq, wakeRequest, cnDrive;
  spio_wb_req_t wbReq;
  spio_wb_rsp_t wbRsp;
  logic [15:0]  padIn, padOut, padOe, pEn, pDrv, pOut, periphIn, extOe, extVal;
  logic [21:0]  cnIn, pullOn, cnVal;
  int           fail_count = 0;
  int           check_count = 0;

  spio_port #(.IMPL_MASK(MASK)) i_dut (.clock(clock), .resetn(resetn), .wbReq(wbReq), .wbRsp(wbRsp),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .periphEnable(pEn), .periphDriving(pDrv),
    .periphOut(pOut), .periphIn(periphIn), .changeNoticeIn(cnIn), .weakPullupOn(pullOn),
    .powerSave(powerSave), .changeIrq(changeIrq), .wakeRequest(wakeRequest));
  spio_pins_model i_pins (.padOut(padOut), .padOe(padOe), .extOe(extOe), .extVal(extVal),
    .padIn(padIn), .cnDrive(cnDrive), .cnVal(cnVal), .weakPullupOn(pullOn), .changeNoticeIn(cnIn));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  function automatic logic [15:0] oeExp(input logic [15:0] lat, input logic [15:0] od);
    return MASK & (~od | ~lat);
  endfunction : oeExp

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkReg

  task automatic chkPin(input logic [15:0] got, input logic [15:0] exp);
    chkReg({16'h0, got}, {16'h0, exp});
  endtask : chkPin

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt

  // Holds the request until ack is seen, then leaves one idle cycle.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: dat};
    @(posedge clock);
    while (wbRsp.ack !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    rd = wbRsp.dat;
    wbReq <= '0;
    if (n >= 20)
      fail_count++;
    @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    xfer(1'b1, adr, dat, d);
  endtask : wr

  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, adr, 32'h0, d);
    chkReg(d, exp);
  endtask : rdChk

  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end

  initial
  begin
    logic [31:0] v, a, e;
    int          i;
    {resetn, powerSave, pEn, pDrv, pOut, extVal, cnVal} = '0;
    wbReq = '0;
    extOe = 16'hFFFF;
    cnDrive = 1'b1;
    void'($urandom(29));
    wt(16);
    resetn <= 1'b1;
    wt(1);
    chkPin(padOe, 16'h0);
    rdChk(OFS_DIRECTION, {16'h0, MASK});
    for (i = 3; i <= 8; i++)
      rdChk(8'(i * 4), 32'h0);
    for (i = 0; i < 6; i++)
    begin
      v = $urandom;
      wr(i[0] ? OFS_PIN_LEVEL : OFS_LATCH, v);
      rdChk(OFS_LATCH, {16'h0, v[15:0] & MASK});
    end
    wr(8'h40, 32'hFFFFFFFF);
    rdChk(8'h40, 32'h0);
    rdChk(OFS_LATCH, {16'h0, v[15:0] & MASK});
    extOe <= 16'h0;
    wr(OFS_DIRECTION, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      v = $urandom;
      a = i[1] ? 32'hFFFF : 32'h0;
      wr(OFS_OPEN_DRAIN, a);
      wr(OFS_LATCH, v);
      chkPin(padOe, oeExp(v[15:0], a[15:0]));
      chkPin(padOut & padOe, v[15:0] & ~a[15:0] & MASK);
      wt(2);
      rdChk(OFS_PIN_LEVEL, {16'h0, v[15:0] & MASK});
    end
    a = $urandom;
    wr(OFS_DIRECTION, {16'h0, a[15:0]});
    wr(OFS_ANALOG_CFG, a);
    wt(2);
    rdChk(OFS_PIN_LEVEL, {16'h0, v[15:0] & ~a[15:0] & MASK});
    wr(OFS_ANALOG_CFG, 32'h0);
    wr(OFS_OPEN_DRAIN, 32'h0);
    wr(OFS_DIRECTION, 32'hFFFF);
    e = $urandom;
    extOe <= 16'hFFFF;
    extVal <= e[15:0];
    wt(3);
    chkPin(padOe, 16'h0);
    rdChk(OFS_PIN_LEVEL, {16'h0, e[15:0] & MASK});
    extOe <= 16'h0;
    wr(OFS_LATCH, 32'h0);
    wr(OFS_DIRECTION, 32'h0);
    v = $urandom;
    pEn <= 16'hFFFF;
    pDrv <= v[15:0];
    pOut <= v[31:16];
    wt(4);
    chkPin(padOe, MASK);
    chkPin(padOut & MASK, v[31:16] & v[15:0] & MASK);
    rdChk(OFS_PIN_LEVEL, {16'h0, v[31:16] & v[15:0] & MASK});
    chkPin(periphIn & MASK, v[31:16] & v[15:0] & MASK);
    pEn <= 16'h0;
    wr(OFS_CN_EN_LOW, 32'hFFFF);
    wr(OFS_CN_EN_HIGH, 32'h3F);
    for (i = 0; i < CN_W; i++)
    begin
      powerSave <= i[0];
      cnVal[i] <= ~cnVal[i];
      wt(4);
      chkPin({15'h0, wakeRequest}, {15'h0, i[0]});
      chkPin({15'h0, changeIrq}, 16'h0001);
      rdChk(OFS_STATUS, 32'h3);
      wr(OFS_STATUS, 32'h1);
      rdChk(OFS_STATUS, 32'h2);
    end
    wr(OFS_CN_EN_LOW, 32'h0);
    wr(OFS_CN_EN_HIGH, 32'h20);
    cnVal <= cnVal ^ 22'h1FFFFF;
    wt(4);
    rdChk(OFS_STATUS, 32'h2);
    wr(OFS_CN_EN_HIGH, 32'h0);
    e = $urandom;
    cnDrive <= 1'b0;
    wr(OFS_PULLUP_LOW, e);
    wr(OFS_PULLUP_HIGH, e >> 16);
    wt(2);
    chkReg({10'h0, pullOn}, {10'h0, e[21:0]});
    rdChk(OFS_CN_LEVEL, {10'h0, e[21:0]});
    wr(OFS_PULLUP_LOW, 32'h0);
    wr(OFS_PULLUP_HIGH, 32'h0);
    chkReg({10'h0, pullOn}, 32'h0);
    resetn <= 1'b0;
    wt(3);
    chkPin(padOe, 16'h0);
    resetn <= 1'b1;
    wt(1);
    rdChk(OFS_DIRECTION, {16'h0, MASK});
    summarize();
  end
endmodule : test_shared_pin_io_port_change_notify
`default_nettype wire
